// >>> rtl/serial_port_core.v
// serial port: baud clock selection, internal generator, control register, tx/rx engines
// Notes on behaviour
// R1: tx bit clock in modes 1 and 3: internal generator, else timer 2 overflow, else timer 1 overflow.
// R2: rx bit clock chosen the same way, independent of the tx selection.
// R3: internal generator rate set by reload value, speed_mode and double_rate.
// R4: rate = 2^double_rate*clk / (4 * 6^(1-speed_mode) * 16 * (256-reload)).
// R5: generator is 8-bit up-counter, reloads on overflow; overflow is one 16x tick, or one half bit in mode 0.
// R6: frame_error_view set: control bit 7 is sticky framing error, cleared by software.
// R7: frame_error_view clear: control bit 7 is mode_bit_hi.
// R8: mode 0 shift /6, 1 8-bit variable, 2 9-bit /32 or /16, 3 9-bit variable.
// R9: multiproc_enable enables multiprocessor filtering in modes 1, 2 and 3.
// R10: frames are received only while receive_enable is set.
// R11: modes 2 and 3 send tx_ninth_bit as the ninth data bit.
// R12: rx_ninth_bit gets ninth bit in modes 2/3, stop bit in mode 1.
// R13: tx_done_flag set after 8th bit in mode 0, at stop start otherwise.
// R14: rx_done_flag set after 8th bit in mode 0; software clears it.
// R15: internal generator serves modes 1 and 3, and mode 0 when selected.
// R16: with framing check on, rx_done_flag rises at the stop bit.
// R17: double_rate doubles the baud rate in modes 1, 2 and 3, except when the bit clock is timer 2 overflow.
// R18: multiprocessor address frames complete only on given or broadcast address match.
`include "serial_map.vh"
`timescale 1ns/100ps
`default_nettype none
module serial_port_core (
    // clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // timer overflow pulses, same clock
    input wire tmr1_ovf_i,
    input wire tmr2_ovf_i,
    // serial pins
    input wire rxd_in_i,
    output reg rxd_out_o,
    output reg rxd_oe_o,
    output reg txd_o,
    // interrupt
    output reg irq_o
);
    reg a_wr_q;
    reg rd_pend_q;
    reg [7:0] a_addr_q;
    reg fe_q, mhi_q, mlo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
    reg run_q, txi_q, rxi_q, spd_q, m0s_q, t2tx_q, t2rx_q, dbl_q, fev_q;
    reg [7:0] reload_q, saddr_q, saden_q, rbuf_q;
    reg [2:0] ist_q, imsk_q;
    reg [4:0] pre_q;
    reg [7:0] gen_q;
    reg t1_div_q, m2_q, m0_ph_q;
    reg [1:0] m0_cnt_q;
    reg rs1_q, rs2_q, rs3_q;
    reg tx_busy_q, rx_busy_q, ninth_q;
    reg [10:0] tx_sr_q;
    reg [3:0] tx_bit_q, tx_sub_q, rx_bit_q, rx_sub_q;
    reg [7:0] rx_dat_q;
    reg [7:0] rd;

    // bus decode; reads take one wait state so a preceding write is visible
    wire acc = hsel_i & htrans_i[1] & hready_i;
    wire [7:0] wd = hwdata_i[7:0];
    wire wr_sc = a_wr_q & (a_addr_q == `SC_OFF);
    wire wr_dat = a_wr_q & (a_addr_q == `DATA_OFF);

    wire [1:0] mode = {mhi_q, mlo_q};
    wire mode0 = (mode == 2'h0);
    wire mode1 = (mode == 2'h1);

    // internal generator
    wire [4:0] pre_last = spd_q ? (dbl_q ? `PRE_FAST_DBL : `PRE_FAST) :
                                  (dbl_q ? `PRE_SLOW_DBL : `PRE_SLOW); // [R4] [R17]
    wire pre_tick = (pre_q == pre_last - 5'h01);
    wire gen_ovf = run_q & pre_tick & (gen_q == 8'hFF); // [R5]

    // 16x tick sources
    wire t1_tick = tmr1_ovf_i & (dbl_q | t1_div_q); // [R17]
    wire m2_tick = dbl_q | m2_q; // [R8] [R17]
    wire tx_tick = (mode == 2'h2) ? m2_tick : txi_q ? gen_ovf :
                   t2tx_q ? tmr2_ovf_i : t1_tick; // [R1] [R3] [R15]
    wire rx_tick = (mode == 2'h2) ? m2_tick : rxi_q ? gen_ovf :
                   t2rx_q ? tmr2_ovf_i : t1_tick; // [R2] [R3] [R15]
    wire m0_half = m0s_q ? gen_ovf : (m0_cnt_q == `M0_HALF_LAST); // [R8] [R15]
    wire bit_end0 = m0_half & m0_ph_q;

    // transmitter
    wire [3:0] tx_last = mode0 ? 4'h7 : mode1 ? 4'h9 : 4'hA;
    wire [3:0] ti_idx = mode0 ? 4'h7 : mode1 ? 4'h8 : 4'h9;
    wire tx_adv = tx_busy_q & (mode0 ? bit_end0 : (tx_tick & (tx_sub_q == `OVS_LAST)));
    wire ti_set = tx_adv & (tx_bit_q == ti_idx); // [R13]

    // receiver
    wire [3:0] ndata = mode1 ? 4'h8 : 4'h9;
    wire [3:0] stop_idx = ndata + 4'h1;
    wire rx_smp = rx_busy_q & ~mode0 & rx_tick & (rx_sub_q == `OVS_MID);
    wire rx_stop = rx_smp & (rx_bit_q == stop_idx);
    wire rx_cmp = (rx_stop & (fev_q | mode1)) |
                  (rx_smp & ~fev_q & ~mode1 & (rx_bit_q == 4'h9)); // [R16]
    wire nb = (mode1 | (rx_bit_q == 4'h9)) ? rs2_q : ninth_q; // [R12]
    wire given_ok = ((rx_dat_q ^ saddr_q) & saden_q) == 8'h00;
    wire [7:0] bcast = saddr_q | saden_q;
    wire bcast_ok = (rx_dat_q & bcast) == bcast;
    wire rx_acc = rx_cmp & ~ri_q & (~mp_q | (nb & (given_ok | bcast_ok))); // [R9] [R18]
    wire m0_rx_done = rx_busy_q & mode0 & bit_end0 & (rx_bit_q == 4'h7);
    wire ri_set = rx_acc | m0_rx_done; // [R14]
    wire fe_set = rx_stop & fev_q & ~rs2_q; // [R6]
    wire rx_start = ~rx_busy_q & ren_q & (mode0 ? (~ri_q & ~tx_busy_q) : (rs3_q & ~rs2_q)); // [R10]
    wire [2:0] ev = {fe_set, ri_set, ti_set};

    always @* begin
        case (a_addr_q)
            `SC_OFF: rd = {fev_q ? fe_q : mhi_q, mlo_q, mp_q, ren_q,
                           tb8_q, rb8_q, ti_q, ri_q}; // [R6] [R7]
            `DATA_OFF: rd = rbuf_q;
            `GCTL_OFF: rd = {3'h0, run_q, txi_q, rxi_q, spd_q, m0s_q};
            `RELOAD_OFF: rd = reload_q;
            `T2SEL_OFF: rd = {2'h0, t2rx_q, t2tx_q, 4'h0};
            `PWR_OFF: rd = {dbl_q, fev_q, 6'h00};
            `ADDR_OFF: rd = saddr_q;
            `AMASK_OFF: rd = saden_q;
            `IST_OFF: rd = {5'h00, ist_q};
            `IMSK_OFF: rd = {5'h00, imsk_q};
            default: rd = 8'h00;
        endcase
    end

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_wr_q <= 1'b0;
            rd_pend_q <= 1'b0;
            a_addr_q <= 8'h00;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            a_wr_q <= acc & hwrite_i;
            rd_pend_q <= acc & ~hwrite_i;
            if (acc) begin
                a_addr_q <= haddr_i[7:0];
            end
            hreadyout_o <= ~(acc & ~hwrite_i);
            if (rd_pend_q) begin
                hrdata_o <= {24'h00_0000, rd};
            end
        end
    end

    // software writes first, hardware sets last so a set beats a same-cycle clear
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {mhi_q, mlo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= `SC_RST;
            fe_q <= 1'b0;
            {run_q, txi_q, rxi_q, spd_q, m0s_q} <= 5'h00;
            {t2tx_q, t2rx_q, dbl_q, fev_q} <= 4'h0;
            reload_q <= `RELOAD_RST;
            saddr_q <= `ADDR_RST;
            saden_q <= `ADDR_RST;
            rbuf_q <= 8'h00;
            ist_q <= 3'h0;
            imsk_q <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            if (wr_sc) begin
                if (fev_q) begin
                    fe_q <= wd[`SC_TOP]; // [R6]
                end else begin
                    mhi_q <= wd[`SC_TOP]; // [R7]
                end
                mlo_q <= wd[`SC_MLO];
                mp_q <= wd[`SC_MP];
                ren_q <= wd[`SC_REN];
                tb8_q <= wd[`SC_TB8];
                rb8_q <= wd[`SC_RB8];
                ti_q <= wd[`SC_TI];
                ri_q <= wd[`SC_RI];
            end
            if (a_wr_q) begin
                case (a_addr_q)
                    `GCTL_OFF: {run_q, txi_q, rxi_q, spd_q, m0s_q} <= wd[4:0];
                    `RELOAD_OFF: reload_q <= wd;
                    `T2SEL_OFF: {t2rx_q, t2tx_q} <= {wd[`T2_RX], wd[`T2_TX]};
                    `PWR_OFF: {dbl_q, fev_q} <= {wd[`PW_DBL], wd[`PW_FEV]};
                    `ADDR_OFF: saddr_q <= wd;
                    `AMASK_OFF: saden_q <= wd;
                    `IST_OFF: ist_q <= ist_q & ~wd[2:0];
                    `IMSK_OFF: imsk_q <= wd[2:0];
                    default: ;
                endcase
            end
            ist_q <= (wr_sc ? ist_q : ist_q) & ~((a_wr_q & (a_addr_q == `IST_OFF)) ?
                     wd[2:0] : 3'h0) | ev;
            irq_o <= |(((ist_q | ev)) & imsk_q);
            if (ti_set) begin
                ti_q <= 1'b1; // [R13]
            end
            if (rx_acc) begin
                rbuf_q <= rx_dat_q;
                rb8_q <= nb; // [R12]
            end
            if (m0_rx_done) begin
                rbuf_q <= {rs2_q, rx_dat_q[7:1]};
            end
            if (ri_set) begin
                ri_q <= 1'b1; // [R14] [R16]
            end
            if (fe_set) begin
                fe_q <= 1'b1; // [R6]
            end
        end
    end

    // prescaler, generator counter and tick dividers
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q <= 5'h00;
            gen_q <= 8'h00;
            t1_div_q <= 1'b0;
            m2_q <= 1'b0;
            m0_cnt_q <= 2'h0;
        end else begin
            pre_q <= pre_tick ? 5'h00 : pre_q + 5'h01;
            if (run_q & pre_tick) begin
                gen_q <= (gen_q == 8'hFF) ? reload_q : gen_q + 8'h01; // [R5]
            end
            if (tmr1_ovf_i) begin
                t1_div_q <= ~t1_div_q;
            end
            m2_q <= ~m2_q;
            m0_cnt_q <= (m0_cnt_q == `M0_HALF_LAST) ? 2'h0 : m0_cnt_q + 2'h1;
        end
    end

    // pin synchroniser; the first stage feeds only the second
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rs1_q <= 1'b1;
            rs2_q <= 1'b1;
            rs3_q <= 1'b1;
        end else begin
            rs1_q <= rxd_in_i;
            rs2_q <= rs1_q;
            rs3_q <= rs2_q;
        end
    end

    // transmitter; a data write while busy is dropped
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_busy_q <= 1'b0;
            tx_sr_q <= 11'h7FF;
            tx_bit_q <= 4'h0;
            tx_sub_q <= 4'h0;
            m0_ph_q <= 1'b0;
            txd_o <= 1'b1;
            rxd_out_o <= 1'b1;
            rxd_oe_o <= 1'b0;
        end else begin
            if (wr_dat & ~tx_busy_q & ~(mode0 & rx_busy_q)) begin
                tx_busy_q <= 1'b1;
                tx_sr_q <= mode0 ? {3'h7, wd} : {1'b1, mode1 | tb8_q, wd, 1'b0}; // [R11]
                tx_bit_q <= 4'h0;
                tx_sub_q <= 4'h0;
            end else if (tx_busy_q) begin
                if (tx_tick) begin
                    tx_sub_q <= tx_sub_q + 4'h1;
                end
                if (tx_adv) begin
                    tx_sr_q <= {1'b1, tx_sr_q[10:1]};
                    tx_bit_q <= tx_bit_q + 4'h1;
                    if (tx_bit_q == tx_last) begin
                        tx_busy_q <= 1'b0;
                    end
                end
            end
            // mode 0 shift clock low in the first half of each bit
            if (mode0 & (tx_busy_q | rx_busy_q)) begin
                if (m0_half) begin
                    m0_ph_q <= ~m0_ph_q;
                end
            end else begin
                m0_ph_q <= 1'b0;
            end
            txd_o <= mode0 ? ~((tx_busy_q | rx_busy_q) & ~m0_ph_q) :
                     (tx_busy_q ? tx_sr_q[0] : 1'b1); // [R8]
            rxd_out_o <= tx_sr_q[0];
            rxd_oe_o <= mode0 & tx_busy_q;
        end
    end

    // receiver
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_busy_q <= 1'b0;
            rx_bit_q <= 4'h0;
            rx_sub_q <= 4'h0;
            rx_dat_q <= 8'h00;
            ninth_q <= 1'b0;
        end else if (rx_start) begin
            rx_busy_q <= 1'b1; // [R10]
            rx_bit_q <= 4'h0;
            rx_sub_q <= 4'h0;
        end else if (rx_busy_q & mode0) begin
            if (bit_end0) begin
                rx_dat_q <= {rs2_q, rx_dat_q[7:1]};
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h7) begin
                    rx_busy_q <= 1'b0;
                end
            end
        end else if (rx_busy_q) begin
            if (rx_tick) begin
                rx_sub_q <= rx_sub_q + 4'h1;
                if (rx_sub_q == `OVS_LAST) begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                end
            end
            if (rx_smp) begin
                if (rx_bit_q == 4'h0) begin
                    rx_busy_q <= ~rs2_q;
                end else if (rx_bit_q <= 4'h8) begin
                    rx_dat_q <= {rs2_q, rx_dat_q[7:1]};
                end else if (rx_bit_q == 4'h9 && !mode1) begin
                    ninth_q <= rs2_q;
                end
                if (rx_bit_q == stop_idx) begin
                    rx_busy_q <= 1'b0;
                end
            end
        end
    end
endmodule // serial_port_core
`default_nettype wire

// >>> rtl/serial_map.vh
// register offsets, field positions, reset values and counts of the serial port
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
`define SC_OFF 8'h98
`define DATA_OFF 8'h9C
`define GCTL_OFF 8'hA0
`define RELOAD_OFF 8'hA4
`define T2SEL_OFF 8'hA8
`define PWR_OFF 8'hAC
`define ADDR_OFF 8'hB0
`define AMASK_OFF 8'hB4
`define IST_OFF 8'hB8
`define IMSK_OFF 8'hBC
`define SC_TOP 7
`define SC_MLO 6
`define SC_MP 5
`define SC_REN 4
`define SC_TB8 3
`define SC_RB8 2
`define SC_TI 1
`define SC_RI 0
`define GC_RUN 4
`define GC_TXI 3
`define GC_RXI 2
`define GC_SPD 1
`define GC_M0S 0
`define T2_RX 5
`define T2_TX 4
`define PW_DBL 7
`define PW_FEV 6
`define EV_TI 0
`define EV_RI 1
`define EV_FE 2
`define SC_RST 8'h00
`define RELOAD_RST 8'h00
`define ADDR_RST 8'h00
`define M0_HALF_LAST 2'h2
`define PRE_FAST_DBL 5'h02
`define PRE_FAST 5'h04
`define PRE_SLOW_DBL 5'h0C
`define PRE_SLOW 5'h18
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`endif

// >>> tb/serial_port_core_assertions.sv
// bus and pin checker for the serial port core
`timescale 1ns/100ps
`default_nettype none
module serial_port_core_assertions (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // pins
    input wire logic rxd_oe_o,
    input wire logic txd_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic mask_wr_q;
    wire take = hsel_i && htrans_i[1] && hready_i;
    wire hole = haddr_i[7:0] < 8'h98 || haddr_i[7:0] > 8'hBC || haddr_i[1:0] != 2'h0;
    // remembers a mask write so its data phase can be judged
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_wr_q <= 1'b0;
        end else begin
            mask_wr_q <= take && hwrite_i && haddr_i[7:0] == 8'hBC;
        end
    end
    property p_okay; hresp_o == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_read_wait; take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
    property p_write_fast; take && hwrite_i |=> hreadyout_o; endproperty
    a_write_fast: assert property (p_write_fast) else $error("write inserted a wait");
    property p_wait_cause; !hreadyout_o |-> $past(take && !hwrite_i); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("wait without a read");
    property p_hole; take && !hwrite_i && hole |-> ##2 hrdata_o == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_upper; hrdata_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_mask_off; mask_wr_q && hwdata_i[2:0] == 3'h0 |-> ##2 !irq_o [*2]; endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
    property p_rst_pins; $rose(rst_b_i) |-> txd_o && !rxd_oe_o && !irq_o; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not idle after reset");
    c_read: cover property (take && !hwrite_i);
    c_irq: cover property ($rose(irq_o));
    c_m0: cover property ($rose(rxd_oe_o));
endmodule // serial_port_core_assertions
bind serial_port_core serial_port_core_assertions u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/serial_peer_model.sv
// far-side serial station: sends frames on the receive line
`timescale 1ns/100ps
`default_nettype none
module serial_peer_model (
    // clock
    input wire logic clock_i,
    // line, idles high
    output logic line_o
);
    initial line_o = 1'b1;
    // f holds start, data lsb first, ninth, stop; a zero stop forces a framing fault
    task automatic send(input logic [10:0] f, input integer n, input integer per);
        integer i;
        for (i = 0; i < n; i++) begin
            @(posedge clock_i);
            line_o <= f[i];
            repeat (per - 1) @(posedge clock_i);
        end
        @(posedge clock_i);
        line_o <= 1'b1;
    endtask
endmodule // serial_peer_model
`default_nettype wire

// >>> tb/test_serial_port_core.sv
// self-checking bench for the serial port core
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_core;
    logic clock_i = 0, rst_b_i = 0, hwrite = 0, t1 = 0, t2 = 1;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    wire [31:0] hrdata;
    wire hready, rxd_out, rxd_oe, txd, irq, peer_line;
    wire line = rxd_oe ? rxd_out : peer_line;
    integer n_errors = 0, checks_done = 0, cyc = 0, i;
    always #10 clock_i = ~clock_i;
    // timer 1 overflows every 2 clocks, timer 2 every clock
    always @(posedge clock_i) begin
        t1 <= ~t1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            finish_test;
        end
    end
    serial_port_core u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(), .tmr1_ovf_i(t1), .tmr2_ovf_i(t2), .rxd_in_i(line), .rxd_out_o(rxd_out),
        .rxd_oe_o(rxd_oe), .txd_o(txd), .irq_o(irq));
    serial_peer_model u_peer (.clock_i(clock_i), .line_o(peer_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // waits for the start edge, then samples each bit in its middle
    task automatic tx_check(input logic [10:0] f, input integer n, input integer per);
        i = 0;
        while (txd !== 1'b0 && i < 3000) begin
            @(posedge clock_i);
            i++;
        end
        repeat (per / 2) @(posedge clock_i);
        for (i = 0; i < n; i++) begin
            check(txd, f[i]);
            repeat (per) @(posedge clock_i);
        end
    endtask
    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset;
        rd_chk(8'h98, 32'h00);
        rd_chk(8'hA4, 32'h00);
        rd_chk(8'hC4, 32'h00);
    endtask
    // reload FF, fastest prescale, double rate: 32 clocks a bit
    task automatic t_gen_tx;
        bus(1, 8'hA4, 32'hFF);
        bus(1, 8'hAC, 32'h80);
        bus(1, 8'hA0, 32'h1E);
        // generator climbs from zero before its first reload; let it settle
        repeat (600) @(posedge clock_i);
        bus(1, 8'hBC, 32'h07);
        bus(1, 8'h98, 32'h40);
        bus(1, 8'h9C, 32'hA5);
        tx_check({2'h3, 8'hA5, 1'b0}, 10, 32);
        rd_chk(8'h98, 32'h42);
        check(irq, 1'b1);
        bus(1, 8'hBC, 32'h00);
        repeat (3) @(posedge clock_i);
        check(irq, 1'b0);
        bus(1, 8'hBC, 32'h07);
        bus(1, 8'hB8, 32'h07);
        repeat (3) @(posedge clock_i);
        check(irq, 1'b0);
        bus(1, 8'h98, 32'hC0);
        bus(1, 8'h9C, 32'h3C);
        tx_check({2'h2, 8'h3C, 1'b0}, 11, 32);
    endtask
    task automatic t_gen_rx;
        u_peer.send({2'h3, 8'h77, 1'b0}, 11, 32);
        rd_chk(8'h98, 32'hC2);
        bus(1, 8'h98, 32'h50);
        u_peer.send({2'h3, 8'h96, 1'b0}, 10, 32);
        rd_chk(8'h9C, 32'h96);
        rd_chk(8'h98, 32'h55);
        bus(1, 8'hAC, 32'hC0);
        // acknowledge the last frame so the faulty one is taken
        bus(1, 8'h98, 32'h50);
        u_peer.send({2'h0, 8'h11, 1'b0}, 10, 32);
        rd_chk(8'h98, 32'hD1);
        rd_chk(8'h9C, 32'h11);
        bus(1, 8'h98, 32'hD0);
        u_peer.send({2'h3, 8'h22, 1'b0}, 10, 32);
        rd_chk(8'h98, 32'hD5);
        bus(1, 8'hAC, 32'h80);
        rd_chk(8'h98, 32'h55);
        bus(1, 8'h98, 32'hF0);
        bus(1, 8'hB0, 32'h5A);
        bus(1, 8'hB4, 32'hFF);
        u_peer.send({2'h3, 8'h33, 1'b0}, 11, 32);
        rd_chk(8'h98, 32'hF0);
        u_peer.send({2'h3, 8'h5A, 1'b0}, 11, 32);
        rd_chk(8'h98, 32'hF5);
    endtask
    // tx from timer 2 at 16 clocks a bit, rx from doubled timer 1 at 32
    task automatic t_timers;
        bus(1, 8'hA0, 32'h10);
        bus(1, 8'hA8, 32'h10);
        bus(1, 8'h98, 32'h50);
        bus(1, 8'h9C, 32'h0F);
        tx_check({2'h3, 8'h0F, 1'b0}, 10, 16);
        u_peer.send({2'h3, 8'hE1, 1'b0}, 10, 32);
        rd_chk(8'h9C, 32'hE1);
        // mode 2 at double rate: one bit every 16 clocks
        bus(1, 8'h98, 32'h80);
        bus(1, 8'h9C, 32'hC3);
        tx_check({2'h2, 8'hC3, 1'b0}, 11, 16);
    endtask
    task automatic t_mode0;
        bus(1, 8'h98, 32'h00);
        bus(1, 8'h9C, 32'h5A);
        for (int k = 0; k < 8; k++) begin
            @(posedge txd);
            check(rxd_out, (32'h5A >> k) & 32'h1);
            check(rxd_oe, 1'b1);
        end
        repeat (8) @(posedge clock_i);
        rd_chk(8'h98, 32'h02);
        // receive with the line idle high: eight ones shifted in
        bus(1, 8'h98, 32'h10);
        repeat (60) @(posedge clock_i);
        rd_chk(8'h98, 32'h11);
        rd_chk(8'h9C, 32'hFF);
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_gen_tx;
        t_gen_rx;
        t_timers;
        t_mode0;
        finish_test;
    end
endmodule // test_serial_port_core
`default_nettype wire
